/* hdl/osc_reference_select.sv */
// Top of the oscillator reference clock selection logic
// How it works
// R1: Main reference source comes from two bits of the read-only option byte.
// R2: Code 01 picks internal oscillator, second pin carries bus clock; 00 unused.
// R3: Code 10 picks RC oscillator, second pin carries bus clock.
// R4: Code 11 picks crystal; second pin carries inverting amplifier output.
// R5: Timebase source comes from two config bits, independent of main choice.
// R6: Timebase code 00 internal, 01 RC, 10 crystal, 11 unused.
// R7: Internal oscillator runs after every reset, whatever the main source.
// R8: RC and crystal never run together; the unselected one stays off.
// R9: RC or crystal reaches timebase only when it is the main source.
// R10: Internal oscillator stops in stop mode when its stop-disable bit is set.
// R11: Main reference and buffered copy feed all but timebase and watchdog.
// R12: Stop disables RC or crystal unless its keep bit was set beforehand.
// R13: System enable turns the active oscillator circuit on or off.
// R14: Wait mode leaves every oscillator and reference output running.
// R15: Source selections are latched after reset and never switched while running; here the timebase field can still change once, at the first config write.
`timescale 1ns/1ps
`include "osc_sel_map.svh"

module osc_reference_select (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [7:0] option_byte_i,
    input wire logic internal_osc_clock_i,
    input wire logic rc_osc_clock_i,
    input wire logic crystal_osc_clock_i,
    input wire logic crystal_amp_out_i,
    input wire logic bus_clock_i,
    input wire logic oscillator_enable_from_sysint_i,
    input wire logic stop_mode_i,
    output logic main_reference_clock_o,
    output logic buffered_reference_clock_o,
    output logic timebase_reference_clock_o,
    output logic watchdog_reference_clock_o,
    output logic osc_output_pin_o,
    output logic osc_output_pin_oe_o,
    output logic internal_osc_enable_o,
    output logic rc_osc_enable_o,
    output logic crystal_osc_enable_o
);
    typedef enum logic [1:0] {
        PWR_RESET,
        PWR_RUN,
        PWR_STOP
    } pwr_state_t;

    osc_sel_pkg::wb_req_t req;
    logic cfg_we;
    logic [7:0] cfg_wdata;
    logic [7:0] status_rd;

    // Option and configuration state
    logic [7:0] opt_reg;
    logic [7:0] opt_next;
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic tb_locked_reg;
    logic tb_locked_next;
    pwr_state_t pwr_reg;
    pwr_state_t pwr_next;
    logic keep_rc_reg;
    logic keep_rc_next;
    logic keep_xtal_reg;
    logic keep_xtal_next;
    logic internal_osc_clock_off_reg;
    logic internal_osc_clock_off_next;

    // Output state
    osc_sel_pkg::osc_set_t en_reg;
    osc_sel_pkg::osc_set_t en_next;
    logic pin_reg;
    logic pin_next;
    logic pin_oe_reg;
    logic pin_oe_next;
    logic wdog_reg;
    logic wdog_next;
    logic buf_reg;
    logic buf_next;

    osc_sel_pkg::src_t main_src;
    osc_sel_pkg::src_t tb_src;
    osc_sel_pkg::osc_set_t levels;
    osc_sel_pkg::osc_set_t tb_avail;
    logic [1:0] main_code;
    logic [1:0] tb_code;
    logic main_clk;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign levels = '{internal: internal_osc_clock_i, rc: rc_osc_clock_i, crystal: crystal_osc_clock_i};

    wb_reg_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_i(req),
        .cfg_rd_i(cfg_reg),
        .opt_rd_i(opt_reg),
        .status_rd_i(status_rd),
        .ack_o(wb_ack_o),
        .dat_o(wb_dat_o),
        .cfg_we_o(cfg_we),
        .cfg_wdata_o(cfg_wdata)
    );

    // R1: main code from option byte
    assign main_code = {opt_reg[`OSC_MAIN_SEL_HI_BIT], opt_reg[`OSC_MAIN_SEL_LO_BIT]};
    // R5: timebase code from config
    assign tb_code = {cfg_reg[`OSC_TB_SEL_HI_BIT], cfg_reg[`OSC_TB_SEL_LO_BIT]};

    always_comb begin
        main_src = osc_sel_pkg::SRC_NONE;
        unique case (main_code)
            // R2: code 00 drives nothing
            `OSC_MAIN_CODE_UNUSED: main_src = osc_sel_pkg::SRC_NONE;
            // R2: internal source
            `OSC_MAIN_CODE_INTERNAL: main_src = osc_sel_pkg::SRC_INTERNAL;
            // R3: RC source
            `OSC_MAIN_CODE_RC: main_src = osc_sel_pkg::SRC_RC;
            // R4: crystal source
            `OSC_MAIN_CODE_CRYSTAL: main_src = osc_sel_pkg::SRC_CRYSTAL;
        endcase
    end

    always_comb begin
        tb_src = osc_sel_pkg::SRC_NONE;
        // R6: timebase decode
        unique case (tb_code)
            `OSC_TB_CODE_INTERNAL: tb_src = osc_sel_pkg::SRC_INTERNAL;
            `OSC_TB_CODE_RC: tb_src = osc_sel_pkg::SRC_RC;
            `OSC_TB_CODE_CRYSTAL: tb_src = osc_sel_pkg::SRC_CRYSTAL;
            `OSC_TB_CODE_UNUSED: tb_src = osc_sel_pkg::SRC_NONE;
        endcase
    end

    // R9: timebase may use RC or crystal only as main source
    assign tb_avail = '{internal: en_reg.internal,
                        rc: en_reg.rc & (main_src == osc_sel_pkg::SRC_RC),
                        crystal: en_reg.crystal & (main_src == osc_sel_pkg::SRC_CRYSTAL)};

    // R11: main reference for clock generator and subsystems
    clock_pick u_main_pick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(main_src),
        .level_i(levels),
        .avail_i(en_reg),
        .clk_o(main_clk)
    );

    // R5: timebase picked separately from the main source
    clock_pick u_tb_pick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(tb_src),
        .level_i(levels),
        .avail_i(tb_avail),
        .clk_o(timebase_reference_clock_o)
    );

    // Option byte and configuration register
    always_comb begin
        opt_next = opt_reg;
        cfg_next = cfg_reg;
        tb_locked_next = tb_locked_reg;
        // R15: option byte taken once, first cycle after reset
        if (pwr_reg == PWR_RESET) begin
            opt_next = option_byte_i;
        end
        if (cfg_we) begin
            cfg_next = cfg_reg & ~`OSC_TB_CFG_MASK | cfg_wdata & `OSC_TB_CFG_MASK;
            // R15: timebase field is write-once so the source changes only at the first write
            if (tb_locked_reg) begin
                cfg_next[`OSC_TB_SEL_HI_BIT] = cfg_reg[`OSC_TB_SEL_HI_BIT];
                cfg_next[`OSC_TB_SEL_LO_BIT] = cfg_reg[`OSC_TB_SEL_LO_BIT];
            end
            tb_locked_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_reg <= `OSC_OPT_RESET;
            cfg_reg <= `OSC_TB_CFG_RESET;
            tb_locked_reg <= 1'b0;
        end else begin
            opt_reg <= opt_next;
            cfg_reg <= cfg_next;
            tb_locked_reg <= tb_locked_next;
        end
    end

    // Power mode tracking; keep bits are frozen at stop entry
    always_comb begin
        pwr_next = pwr_reg;
        keep_rc_next = keep_rc_reg;
        keep_xtal_next = keep_xtal_reg;
        internal_osc_clock_off_next = internal_osc_clock_off_reg;
        unique case (pwr_reg)
            PWR_RESET: begin
                pwr_next = PWR_RUN;
            end
            PWR_RUN: begin
                if (stop_mode_i) begin
                    pwr_next = PWR_STOP;
                    // R12: keep bits must be set before stop entry
                    keep_rc_next = cfg_reg[`OSC_RC_STOP_KEEP_BIT];
                    keep_xtal_next = cfg_reg[`OSC_XTAL_STOP_KEEP_BIT];
                    // R10: stop-disable sampled on entry
                    internal_osc_clock_off_next = cfg_reg[`OSC_INTERNAL_OSC_CLOCK_STOP_DIS_BIT];
                end
            end
            PWR_STOP: begin
                if (!stop_mode_i) begin
                    pwr_next = PWR_RUN;
                    keep_rc_next = 1'b0;
                    keep_xtal_next = 1'b0;
                    internal_osc_clock_off_next = 1'b0;
                end
            end
            default: begin
                pwr_next = PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_reg <= PWR_RESET;
            keep_rc_reg <= 1'b0;
            keep_xtal_reg <= 1'b0;
            internal_osc_clock_off_reg <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            keep_rc_reg <= keep_rc_next;
            keep_xtal_reg <= keep_xtal_next;
            internal_osc_clock_off_reg <= internal_osc_clock_off_next;
        end
    end

    // Oscillator enables and pin drive
    always_comb begin
        // R7: internal oscillator on after reset
        // R13: system enable gates the active circuit
        en_next.internal = oscillator_enable_from_sysint_i;
        // R10: internal off in stop when disabled
        if (pwr_reg == PWR_STOP && internal_osc_clock_off_reg) begin
            en_next.internal = 1'b0;
        end
        // R8: only the selected one of RC and crystal runs
        en_next.rc = oscillator_enable_from_sysint_i & (main_src == osc_sel_pkg::SRC_RC);
        en_next.crystal = oscillator_enable_from_sysint_i & (main_src == osc_sel_pkg::SRC_CRYSTAL);
        // R12: stop kills RC or crystal unless kept
        if (pwr_reg == PWR_STOP) begin
            en_next.rc = en_next.rc & keep_rc_reg;
            en_next.crystal = en_next.crystal & keep_xtal_reg;
        end
        // R14: wait mode has no input here, so nothing stops in wait
        pin_next = 1'b0;
        pin_oe_next = 1'b0;
        unique case (main_src)
            osc_sel_pkg::SRC_NONE: begin
                pin_next = 1'b0;
                pin_oe_next = 1'b0;
            end
            // R2: bus clock on second pin
            osc_sel_pkg::SRC_INTERNAL: begin
                pin_next = bus_clock_i;
                pin_oe_next = 1'b1;
            end
            // R3: bus clock on second pin
            osc_sel_pkg::SRC_RC: begin
                pin_next = bus_clock_i;
                pin_oe_next = 1'b1;
            end
            // R4: amplifier output on second pin
            osc_sel_pkg::SRC_CRYSTAL: begin
                pin_next = crystal_amp_out_i;
                pin_oe_next = 1'b1;
            end
        endcase
        // R11: watchdog always takes the internal clock
        wdog_next = internal_osc_clock_i & en_reg.internal;
        // R11: buffered copy follows main reference
        buf_next = main_clk;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= '{internal: 1'b1, rc: 1'b0, crystal: 1'b0};
            pin_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            wdog_reg <= 1'b0;
            buf_reg <= 1'b0;
        end else begin
            en_reg <= en_next;
            pin_reg <= pin_next;
            pin_oe_reg <= pin_oe_next;
            wdog_reg <= wdog_next;
            buf_reg <= buf_next;
        end
    end

    always_comb begin
        status_rd = 8'h00;
        status_rd[`OSC_ST_INTERNAL_EN_BIT] = en_reg.internal;
        status_rd[`OSC_ST_RC_EN_BIT] = en_reg.rc;
        status_rd[`OSC_ST_XTAL_EN_BIT] = en_reg.crystal;
        status_rd[`OSC_ST_STOP_BIT] = (pwr_reg == PWR_STOP);
        status_rd[`OSC_ST_MAIN_BAD_BIT] = (main_src == osc_sel_pkg::SRC_NONE);
        status_rd[`OSC_ST_TB_UNAVAIL_BIT] = (tb_src == osc_sel_pkg::SRC_NONE) |
            (tb_src == osc_sel_pkg::SRC_RC && main_src != osc_sel_pkg::SRC_RC) |
            (tb_src == osc_sel_pkg::SRC_CRYSTAL && main_src != osc_sel_pkg::SRC_CRYSTAL);
        status_rd[`OSC_ST_TB_LOCKED_BIT] = tb_locked_reg;
    end

    assign main_reference_clock_o = main_clk;
    assign buffered_reference_clock_o = buf_reg;
    assign watchdog_reference_clock_o = wdog_reg;
    assign osc_output_pin_o = pin_reg;
    assign osc_output_pin_oe_o = pin_oe_reg;
    assign internal_osc_enable_o = en_reg.internal;
    assign rc_osc_enable_o = en_reg.rc;
    assign crystal_osc_enable_o = en_reg.crystal;

endmodule : osc_reference_select

/* hdl/osc_sel_map.svh */
// Offsets, field positions and reset values of the reference clock select block
`ifndef OSC_SEL_MAP_SVH
`define OSC_SEL_MAP_SVH

`define OSC_ADR_W 18
`define OSC_IDX_W 16
`define OSC_TB_CFG_IDX 16'h001d
`define OSC_OPT_IDX 16'hffcf
`define OSC_STATUS_IDX 16'h0020

`define OSC_MAIN_SEL_LO_BIT 0
`define OSC_MAIN_SEL_HI_BIT 1

`define OSC_INTERNAL_OSC_CLOCK_STOP_DIS_BIT 0
`define OSC_TB_SEL_LO_BIT 1
`define OSC_TB_SEL_HI_BIT 2
`define OSC_RC_STOP_KEEP_BIT 3
`define OSC_XTAL_STOP_KEEP_BIT 4
`define OSC_TB_CFG_MASK 8'h1f
`define OSC_TB_CFG_RESET 8'h00
`define OSC_OPT_RESET 8'h00

`define OSC_MAIN_CODE_UNUSED 2'h0
`define OSC_MAIN_CODE_INTERNAL 2'h1
`define OSC_MAIN_CODE_RC 2'h2
`define OSC_MAIN_CODE_CRYSTAL 2'h3
`define OSC_TB_CODE_INTERNAL 2'h0
`define OSC_TB_CODE_RC 2'h1
`define OSC_TB_CODE_CRYSTAL 2'h2
`define OSC_TB_CODE_UNUSED 2'h3

`define OSC_ST_INTERNAL_EN_BIT 0
`define OSC_ST_RC_EN_BIT 1
`define OSC_ST_XTAL_EN_BIT 2
`define OSC_ST_STOP_BIT 3
`define OSC_ST_MAIN_BAD_BIT 4
`define OSC_ST_TB_UNAVAIL_BIT 5
`define OSC_ST_TB_LOCKED_BIT 6

`endif

/* hdl/osc_sel_pkg.sv */
// Types shared by the reference clock select block
package osc_sel_pkg;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_INTERNAL,
        SRC_RC,
        SRC_CRYSTAL
    } src_t;

    typedef struct packed {
        logic internal;
        logic rc;
        logic crystal;
    } osc_set_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [17:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage : osc_sel_pkg

/* hdl/wb_reg_slave.sv */
// Classic Wishbone slave front end for the clock select registers
`timescale 1ns/1ps
`include "osc_sel_map.svh"

module wb_reg_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire osc_sel_pkg::wb_req_t req_i,
    input wire logic [7:0] cfg_rd_i,
    input wire logic [7:0] opt_rd_i,
    input wire logic [7:0] status_rd_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    output logic cfg_we_o,
    output logic [7:0] cfg_wdata_o
);
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic [`OSC_IDX_W-1:0] idx;
    logic aligned;

    assign idx = req_i.adr[`OSC_ADR_W-1:2];
    assign aligned = (req_i.adr[1:0] == 2'h0);

    always_comb begin
        // One wait state, ack dropped after one cycle
        ack_next = req_i.cyc & req_i.stb & ~ack_reg;
        dat_next = 32'h0000_0000;
        if (aligned) begin
            unique case (idx)
                `OSC_TB_CFG_IDX: dat_next = {24'h00_0000, cfg_rd_i};
                `OSC_OPT_IDX: dat_next = {24'h00_0000, opt_rd_i};
                `OSC_STATUS_IDX: dat_next = {24'h00_0000, status_rd_i};
                default: dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // Write lands on the edge where the master sees ack
    assign cfg_we_o = req_i.cyc & req_i.stb & req_i.we & ack_reg & req_i.sel[0] & aligned &
                      (idx == `OSC_TB_CFG_IDX);
    assign cfg_wdata_o = req_i.dat[7:0];
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

endmodule : wb_reg_slave

/* hdl/clock_pick.sv */
// Registered selector of one sampled oscillator level
`timescale 1ns/1ps

module clock_pick (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire osc_sel_pkg::src_t sel_i,
    input wire osc_sel_pkg::osc_set_t level_i,
    input wire osc_sel_pkg::osc_set_t avail_i,
    output logic clk_o
);
    logic out_reg;
    logic out_next;

    always_comb begin
        out_next = 1'b0;
        unique case (sel_i)
            osc_sel_pkg::SRC_NONE: out_next = 1'b0;
            osc_sel_pkg::SRC_INTERNAL: out_next = level_i.internal & avail_i.internal;
            osc_sel_pkg::SRC_RC: out_next = level_i.rc & avail_i.rc;
            osc_sel_pkg::SRC_CRYSTAL: out_next = level_i.crystal & avail_i.crystal;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign clk_o = out_reg;

endmodule : clock_pick

/* verif/osc_reference_select_properties.sv */
// Concurrent checks on the reference clock select top ports
`timescale 1ns/1ps

module osc_reference_select_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic oscillator_enable_from_sysint_i,
    input wire logic stop_mode_i,
    input wire logic main_reference_clock_o,
    input wire logic buffered_reference_clock_o,
    input wire logic watchdog_reference_clock_o,
    input wire logic internal_osc_enable_o,
    input wire logic rc_osc_enable_o,
    input wire logic crystal_osc_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    chk_rc_xtal_excl: assert property (!(rc_osc_enable_o && crystal_osc_enable_o))
        else $error("rc and crystal both enabled");
    chk_int_after_reset: assert property ($fell(rst_i) && oscillator_enable_from_sysint_i |-> internal_osc_enable_o)
        else $error("internal oscillator off after reset");
    chk_int_running: assert property ((oscillator_enable_from_sysint_i && !stop_mode_i) [*4] |-> internal_osc_enable_o)
        else $error("internal oscillator off while running");
    chk_sysint_off: assert property (!oscillator_enable_from_sysint_i [*3] |->
        !internal_osc_enable_o && !rc_osc_enable_o && !crystal_osc_enable_o)
        else $error("oscillator left on with system enable low");
    chk_main_idle: assert property ((!internal_osc_enable_o && !rc_osc_enable_o && !crystal_osc_enable_o) [*4]
        |-> !main_reference_clock_o && !buffered_reference_clock_o)
        else $error("main reference runs with all oscillators off");
    chk_wdog_idle: assert property (!internal_osc_enable_o && !$past(internal_osc_enable_o)
        |-> !watchdog_reference_clock_o)
        else $error("watchdog clock runs with internal oscillator off");
endmodule : osc_reference_select_properties

bind osc_reference_select osc_reference_select_properties i_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .oscillator_enable_from_sysint_i(oscillator_enable_from_sysint_i),
    .stop_mode_i(stop_mode_i),
    .main_reference_clock_o(main_reference_clock_o),
    .buffered_reference_clock_o(buffered_reference_clock_o),
    .watchdog_reference_clock_o(watchdog_reference_clock_o),
    .internal_osc_enable_o(internal_osc_enable_o),
    .rc_osc_enable_o(rc_osc_enable_o),
    .crystal_osc_enable_o(crystal_osc_enable_o)
);

/* verif/osc_reference_select_tb_top.sv */
// Self-checking bench for the reference clock select block
`timescale 1ns/1ps

module osc_reference_select_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [17:0] adr = 18'h00000;
    logic [31:0] wdat = 32'h00000000;
    logic [7:0] opt = 8'h00;
    logic [2:0] lv = 3'h0;
    logic amp = 1'b0, bclk = 1'b0, sysen = 1'b1, stopm = 1'b0;
    logic [3:0] sel = 4'h0, wsel = 4'hf;
    logic ack, mref, bref, tref, wref, pin, pin_oe, ien, ren, xen;
    logic [31:0] rdat, q;
    logic [7:0] r, c1, c2;
    integer seed = 48372;
    int err_count = 0;
    int cmp_count = 0;

    always #25 clk_i = ~clk_i;

    osc_reference_select i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .option_byte_i(opt), .internal_osc_clock_i(lv[2]), .rc_osc_clock_i(lv[1]),
        .crystal_osc_clock_i(lv[0]), .crystal_amp_out_i(amp), .bus_clock_i(bclk),
        .oscillator_enable_from_sysint_i(sysen), .stop_mode_i(stopm),
        .main_reference_clock_o(mref), .buffered_reference_clock_o(bref),
        .timebase_reference_clock_o(tref), .watchdog_reference_clock_o(wref),
        .osc_output_pin_o(pin), .osc_output_pin_oe_o(pin_oe), .internal_osc_enable_o(ien),
        .rc_osc_enable_o(ren), .crystal_osc_enable_o(xen)
    );

    function automatic logic f_main(input logic [1:0] m, input logic [2:0] l);
        return (m == 2'h0) ? 1'b0 : l[3 - int'(m)];
    endfunction : f_main

    // Rc or crystal only reaches the timebase when it is also main
    function automatic logic f_tb(input logic [1:0] m, input logic [1:0] t, input logic [2:0] l);
        if (t == 2'h0) return l[2];
        if (t == 2'h1 && m == 2'h2) return l[1];
        if (t == 2'h2 && m == 2'h3) return l[0];
        return 1'b0;
    endfunction : f_tb

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    // Waits on ack, never on a fixed count
    task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) err_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask : wb

    task automatic do_reset(input logic [7:0] o);
        opt <= o;
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : do_reset

    task automatic en_chk(input logic i, input logic rr, input logic x);
        cmp_bit(ien, i);
        cmp_bit(ren, rr);
        cmp_bit(xen, x);
    endtask : en_chk

    // Levels held steady so pick latency does not matter
    task automatic sense(input logic [1:0] m, input logic [1:0] t);
        logic [4:0] l;
        l = $random(seed);
        lv <= l[2:0];
        amp <= l[3];
        bclk <= l[4];
        repeat (4) @(posedge clk_i);
        cmp_bit(mref, f_main(m, l[2:0]));
        cmp_bit(bref, f_main(m, l[2:0]));
        cmp_bit(tref, f_tb(m, t, l[2:0]));
        cmp_bit(wref, l[2]);
        cmp_bit(pin_oe, m != 2'h0);
        if (m != 2'h0) cmp_bit(pin, (m == 2'h3) ? l[3] : l[4]);
    endtask : sense

    task automatic conclude;
        $display("comparisons %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        #400000;
        err_count++;
        conclude();
    end

    initial begin
        for (int m = 0; m < 4; m++) begin
            for (int t = 0; t < 4; t++) begin
                r = $random(seed);
                do_reset({r[7:2], 2'(m)});
                en_chk(1'b1, m == 2, m == 3);
                wb(1'b0, 18'h3ff3c, 8'h00);
                cmp_word(q, {24'h000000, opt});
                wb(1'b1, 18'h3ff3c, ~opt);
                wb(1'b0, 18'h3ff3c, 8'h00);
                cmp_word(q, {24'h000000, opt});
                wb(1'b0, 18'h00100, 8'h00);
                cmp_word(q, 32'h00000000);
                c1 = $random(seed);
                c1 = {3'h0, c1[4:3], 2'(t), c1[0]};
                wb(1'b1, 18'h00074, c1);
                repeat (2) sense(2'(m), 2'(t));
                // Status: enables, source flags and field lock
                wb(1'b0, 18'h00080, 8'h00);
                cmp_word(q, {25'h0, 1'b1, t == 3 || (t == 1 && m != 2) || (t == 2 && m != 3),
                             m == 0, 1'b0, m == 3, m == 2, 1'b1});
                // Misaligned access reads zero
                wb(1'b0, 18'h00076, 8'h00);
                cmp_word(q, 32'h00000000);
                // Later write must leave the timebase field alone
                c2 = $random(seed);
                wb(1'b1, 18'h00074, c2);
                // Lane 0 disabled, write must be ignored
                wsel = 4'he;
                wb(1'b1, 18'h00074, ~c2);
                wsel = 4'hf;
                wb(1'b0, 18'h00074, 8'h00);
                cmp_word(q, {27'h0, c2[4:3], 2'(t), c2[0]});
                sense(2'(m), 2'(t));
                stopm <= 1'b1;
                repeat (4) @(posedge clk_i);
                en_chk(!c2[0], m == 2 && c2[3], m == 3 && c2[4]);
                stopm <= 1'b0;
                repeat (4) @(posedge clk_i);
                en_chk(1'b1, m == 2, m == 3);
                sysen <= 1'b0;
                repeat (6) @(posedge clk_i);
                en_chk(1'b0, 1'b0, 1'b0);
                cmp_bit(mref, 1'b0);
                sysen <= 1'b1;
                repeat (4) @(posedge clk_i);
            end
        end
        conclude();
    end
endmodule : osc_reference_select_tb_top
